//--- rtl/srf_defines.svh
// Constants for the card response and data packet framer.
//Contract
//- Register responses 136 bits, all others 48
//- CRC7 in bits 7:1, skipped for OCR
//- Index in 45:40, card status in 39:8
//- After each written block, wait out busy
//- Busy variant response: check DAT0 busy afterwards
//- Register response: ones in 133:128, register bits
//- OCR response: ones in index and CRC field
//- Fast I/O response index 100111, argument fields
//- I/O OCR response layout with zero stuff bits
//- Interrupt response index 101000, RCA or zero
//- I/O access response index 11010X, zero stuff
//- Published address response index 000011, RCA upper
//- Interface condition response index 001000, zero reserved
//- 1-bit bus mandatory, 4 and 8 optional
//- After reset, data moves on DAT0 only
//- Card status refers to previous command
//- Error flags placed in status bits 31:26
//- Status bit 25 shows card locked
//- Extended status is a separate 512-bit block
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH
`define SRF_SHORT_BITS 8'h30
`define SRF_LONG_BITS 8'h88
`define SRF_SHORT_TOP 8'h2F
`define SRF_LONG_CRC_TOP 8'h7F
`define SRF_CRC_LO 8'h08
`define SRF_CRC7_POLY 7'h09
`define SRF_CRC16_POLY 16'h1021
`define SRF_CRC16_LAST 5'h0F
`define SRF_IDX_ONES 6'h3F
`define SRF_IDX_FASTIO 6'h27
`define SRF_IDX_IRQ 6'h28
`define SRF_IDX_IOACC_HI 5'h1A
`define SRF_IDX_RCA 6'h03
`define SRF_IDX_IFCOND 6'h08
`define SRF_CRC_ONES 7'h7F
`define SRF_BUSY_GAP 4'h8
`define SRF_SD_STATUS_BYTES 10'h040
`define SRF_LOCK_BIT 33
`define SRF_ERR_HI 39
`define SRF_ERR_LO 34
`define SRF_LANES_1 8'h01
`define SRF_LANES_4 8'h0F
`define SRF_LANES_8 8'hFF
`endif

//--- rtl/srf_pkg.sv
// Types for the card response and data packet framer.
package srf_pkg;
	typedef enum logic [3:0] {SRF_R1, SRF_R1B, SRF_R2, SRF_R3, SRF_R4,
		SRF_R4IO, SRF_R5, SRF_R5IO, SRF_R6, SRF_R7} srf_kind_t;
	typedef enum logic [1:0] {SRF_W1, SRF_W4, SRF_W8, SRF_WRSV} srf_width_t;
	typedef enum logic [1:0] {SRF_RX_IDLE, SRF_RX_WAIT, SRF_RX_SHIFT,
		SRF_RX_DONE} srf_rx_t;
	typedef enum logic [1:0] {SRF_B_IDLE, SRF_B_GAP, SRF_B_WAIT} srf_busy_t;
	typedef enum logic [2:0] {SRF_T_IDLE, SRF_T_START, SRF_T_DATA,
		SRF_T_CRC, SRF_T_END, SRF_T_STOP} srf_tx_t;
endpackage : srf_pkg

//--- rtl/srf_framer.sv
// Host side response receiver, write data packet framer and busy watch.
`timescale 1ns/1ns
`include "srf_defines.svh"
module srf_framer (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic nrst_in,
	// Card bus pins; the inputs come from outside the clock domain.
	input wire logic sd_clk_in,
	input wire logic cmd_in,
	input wire logic dat0_in,
	output logic [7:0] dat_out,
	output logic [7:0] dat_oe_out,
	// Response control.
	input wire logic resp_arm_in,
	input wire logic [3:0] resp_kind_in,
	input wire logic [5:0] cmd_index_in,
	// Response results.
	output logic resp_valid_out,
	output logic [5:0] resp_index_out,
	output logic [31:0] resp_arg_out,
	output logic [126:0] resp_reg_out,
	output logic resp_crc_err_out,
	output logic resp_frame_err_out,
	output logic card_err_out,
	output logic card_locked_out,
	output logic busy_out,
	// Write block control.
	input wire logic wr_start_in,
	input wire logic [1:0] bus_width_in,
	input wire logic [9:0] blk_len_in,
	input wire logic sd_status_sel_in,
	output logic blk_done_out,
	// Write byte stream.
	input wire logic wr_valid_in,
	input wire logic [7:0] wr_data_in,
	output logic wr_ready_out
);
	// CRC7 step over one command line bit.
	function automatic logic [6:0] crc7_step(input logic [6:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[6];
		crc7_step = {c[5:0], 1'b0} ^ (fb ? `SRF_CRC7_POLY : 7'h00);
	endfunction : crc7_step

	// CRC16 step over one data lane bit.
	function automatic logic [15:0] crc16_step(input logic [15:0] c,
		input logic b);
		logic fb;
		fb = b ^ c[15];
		crc16_step = {c[14:0], 1'b0} ^ (fb ? `SRF_CRC16_POLY : 16'h0000);
	endfunction : crc16_step

	// Fixed field checks per response kind.
	function automatic logic fields_ok(input srf_pkg::srf_kind_t k,
		input logic [135:0] s, input logic [5:0] exp);
		logic [5:0] ix;
		ix = s[45:40];
		case (k)
			srf_pkg::SRF_R1, srf_pkg::SRF_R1B: fields_ok = (ix == exp);
			srf_pkg::SRF_R2: fields_ok = (s[133:128] == `SRF_IDX_ONES);
			srf_pkg::SRF_R3: fields_ok = (ix == `SRF_IDX_ONES) &&
				(s[7:1] == `SRF_CRC_ONES);
			srf_pkg::SRF_R4: fields_ok = (ix == `SRF_IDX_FASTIO);
			srf_pkg::SRF_R4IO: fields_ok = (ix == `SRF_IDX_ONES) &&
				(s[34:32] == 3'h0) && (s[7:1] == `SRF_CRC_ONES);
			srf_pkg::SRF_R5: fields_ok = (ix == `SRF_IDX_IRQ);
			srf_pkg::SRF_R5IO: fields_ok = (ix[5:1] == `SRF_IDX_IOACC_HI) &&
				(s[39:24] == 16'h0000);
			srf_pkg::SRF_R6: fields_ok = (ix == `SRF_IDX_RCA);
			srf_pkg::SRF_R7: fields_ok = (ix == `SRF_IDX_IFCOND) &&
				(s[39:20] == 20'h00000);
			default: fields_ok = 1'b0;
		endcase
	endfunction : fields_ok

	// Lane values for one beat of a data byte.
	function automatic logic [7:0] lane_bits(input srf_pkg::srf_width_t w,
		input logic [7:0] b, input logic [2:0] beat);
		case (w)
			srf_pkg::SRF_W4: lane_bits = beat[0] ? {4'h0, b[3:0]} :
				{4'h0, b[7:4]};
			srf_pkg::SRF_W8: lane_bits = b;
			default: lane_bits = {7'h00, b[3'h7 - beat]};
		endcase
	endfunction : lane_bits

	logic clk_s1_r, clk_s2_r, clk_s3_r;
	logic cmd_s1_r, cmd_s2_r, dat0_s1_r, dat0_s2_r;
	srf_pkg::srf_rx_t rstate_r;
	srf_pkg::srf_kind_t kind_r;
	srf_pkg::srf_busy_t bstate_r, bstate_nxt;
	srf_pkg::srf_tx_t tstate_r;
	srf_pkg::srf_width_t width_r;
	logic long_r;
	logic [5:0] idx_exp_r;
	logic [135:0] sr_r;
	logic [7:0] bits_left_r;
	logic [6:0] crc_r;
	logic [3:0] gap_r;
	logic [7:0] mem_r [2];
	logic wp_r, rp_r;
	logic [1:0] cnt_r, cnt_nxt;
	logic [7:0] cur_r;
	logic [2:0] beat_r;
	logic [9:0] bytes_left_r;
	logic [4:0] crc_cnt_r;
	logic [15:0] crc16_r [8];
	logic [7:0] crc_msb;

	// Edges of the card clock seen through the synchroniser.
	wire sd_rise = clk_s2_r & ~clk_s3_r;
	wire sd_fall = ~clk_s2_r & clk_s3_r;

	// Two-flop synchronisers; the first stage feeds only the second.
	always_ff @(posedge clk_in) begin
		clk_s1_r <= sd_clk_in;
		clk_s2_r <= clk_s1_r;
		clk_s3_r <= clk_s2_r;
		cmd_s1_r <= cmd_in;
		cmd_s2_r <= cmd_s1_r;
		dat0_s1_r <= dat0_in;
		dat0_s2_r <= dat0_s1_r;
	end

	wire arm_long = (resp_kind_in == 4'(srf_pkg::SRF_R2));
	wire [7:0] rx_pos = bits_left_r - 8'h01;
	wire [7:0] crc_top = long_r ? `SRF_LONG_CRC_TOP : `SRF_SHORT_TOP;
	wire rx_step = sd_rise && ((rstate_r == srf_pkg::SRF_RX_SHIFT) ||
		((rstate_r == srf_pkg::SRF_RX_WAIT) && !cmd_s2_r));
	// the CRC covers bits 47:8 of a short token and bits 127:8 of a long one.
	wire crc_feed = (rx_pos >= `SRF_CRC_LO) && (rx_pos <= crc_top);
	wire crc_skip = (kind_r == srf_pkg::SRF_R3) ||
		(kind_r == srf_pkg::SRF_R4IO);
	wire crc_bad = !crc_skip && (sr_r[7:1] != crc_r);
	wire dir_bad = long_r ? sr_r[134] : sr_r[46];
	wire fields_bad = !fields_ok(kind_r, sr_r, idx_exp_r);
	wire frame_bad = fields_bad || dir_bad || !sr_r[0];
	wire is_r1 = (kind_r == srf_pkg::SRF_R1) || (kind_r == srf_pkg::SRF_R1B);
	wire rx_done = rstate_r == srf_pkg::SRF_RX_DONE;

	// Response receiver state; a fresh arm restarts any token in flight.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			rstate_r <= srf_pkg::SRF_RX_IDLE;
		end else if (resp_arm_in) begin
			rstate_r <= srf_pkg::SRF_RX_WAIT;
		end else if (rx_step && bits_left_r == 8'h01) begin
			rstate_r <= srf_pkg::SRF_RX_DONE;
		end else if (rx_step) begin
			rstate_r <= srf_pkg::SRF_RX_SHIFT;
		end else if (rx_done) begin
			rstate_r <= srf_pkg::SRF_RX_IDLE;
		end
	end

	// shift register and bit count, MSB arrives first.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			sr_r <= '0;
			bits_left_r <= 8'h00;
			crc_r <= 7'h00;
			kind_r <= srf_pkg::SRF_R1;
			long_r <= 1'b0;
			idx_exp_r <= 6'h00;
		end else if (resp_arm_in) begin
			bits_left_r <= arm_long ? `SRF_LONG_BITS : `SRF_SHORT_BITS;
			crc_r <= 7'h00;
			kind_r <= srf_pkg::srf_kind_t'(resp_kind_in);
			long_r <= arm_long;
			idx_exp_r <= cmd_index_in;
		end else if (rx_step) begin
			sr_r <= {sr_r[134:0], cmd_s2_r};
			bits_left_r <= rx_pos;
			if (crc_feed) begin
				crc_r <= crc7_step(crc_r, cmd_s2_r);
			end
		end
	end

	// report index, argument and register bits once per token.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			resp_valid_out <= 1'b0;
			resp_index_out <= 6'h00;
			resp_arg_out <= 32'h0000_0000;
			resp_reg_out <= '0;
			resp_crc_err_out <= 1'b0;
			resp_frame_err_out <= 1'b0;
		end else begin
			resp_valid_out <= rx_done;
			if (rx_done) begin
				resp_index_out <= sr_r[45:40];
				resp_arg_out <= sr_r[39:8];
				resp_reg_out <= sr_r[127:1];
				resp_crc_err_out <= crc_bad;
				resp_frame_err_out <= frame_bad;
			end
		end
	end

	// status flags track the latest good normal response.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			card_err_out <= 1'b0;
			card_locked_out <= 1'b0;
		end else if (rx_done && is_r1 && !frame_bad && !crc_bad) begin
			// any error flag in status bits 31:26.
			card_err_out <= |sr_r[`SRF_ERR_HI:`SRF_ERR_LO];
			// locked flag is a level, not sticky.
			card_locked_out <= sr_r[`SRF_LOCK_BIT];
		end
	end

	// Busy watch: wait out the status token gap, then until DAT0 rises.
	wire busy_req_r1b = rx_done && (kind_r == srf_pkg::SRF_R1B);
	wire busy_req_blk = sd_fall && (tstate_r == srf_pkg::SRF_T_STOP);
	always_comb begin
		bstate_nxt = bstate_r;
		case (bstate_r)
			srf_pkg::SRF_B_IDLE: begin
				// start watching after block or busy response.
				if (busy_req_r1b || busy_req_blk) begin
					bstate_nxt = srf_pkg::SRF_B_GAP;
				end
			end
			srf_pkg::SRF_B_GAP: begin
				if (sd_rise && gap_r == 4'h1) begin
					bstate_nxt = srf_pkg::SRF_B_WAIT;
				end
			end
			default: begin
				if (sd_rise && dat0_s2_r) begin
					bstate_nxt = srf_pkg::SRF_B_IDLE;
				end
			end
		endcase
	end

	// Busy state, gap counter and the busy flag itself.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			bstate_r <= srf_pkg::SRF_B_IDLE;
			gap_r <= 4'h0;
			busy_out <= 1'b0;
		end else begin
			bstate_r <= bstate_nxt;
			busy_out <= bstate_nxt != srf_pkg::SRF_B_IDLE;
			if (bstate_r == srf_pkg::SRF_B_IDLE) begin
				gap_r <= `SRF_BUSY_GAP;
			end else if (sd_rise && gap_r != 4'h0) begin
				gap_r <= gap_r - 4'h1;
			end
		end
	end

	// width select; anything but 4 or 8 falls back to DAT0.
	wire [7:0] lanes = (width_r == srf_pkg::SRF_W8) ? `SRF_LANES_8 :
		(width_r == srf_pkg::SRF_W4) ? `SRF_LANES_4 : `SRF_LANES_1;
	wire [2:0] last_beat = (width_r == srf_pkg::SRF_W8) ? 3'h0 :
		(width_r == srf_pkg::SRF_W4) ? 3'h1 : 3'h7;
	wire [1:0] w_in = (bus_width_in == 2'(srf_pkg::SRF_WRSV)) ?
		2'(srf_pkg::SRF_W1) : bus_width_in;
	// the extended status block has its own fixed length.
	wire [9:0] len_sel = sd_status_sel_in ? `SRF_SD_STATUS_BYTES : blk_len_in;
	wire in_data = (tstate_r == srf_pkg::SRF_T_DATA) && sd_fall;
	wire starved = (beat_r == 3'h0) && (cnt_r == 2'h0);
	wire tx_beat = in_data && !starved;
	wire tx_load = tx_beat && (beat_r == 3'h0);
	wire [7:0] tx_byte = (beat_r == 3'h0) ? mem_r[rp_r] : cur_r;
	wire [7:0] tx_bits = lane_bits(width_r, tx_byte, beat_r);
	wire byte_end = tx_beat && (beat_r == last_beat);
	wire push = wr_valid_in && wr_ready_out;

	// Two-entry buffer; a stalled bus holds the source off through ready.
	always_comb begin
		case ({push, tx_load})
			2'b10: cnt_nxt = cnt_r + 2'h1;
			2'b01: cnt_nxt = cnt_r - 2'h1;
			default: cnt_nxt = cnt_r;
		endcase
	end

	// Buffer storage and pointers.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
			wr_ready_out <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			wr_ready_out <= cnt_nxt != 2'h2;
			if (push) begin
				mem_r[wp_r] <= wr_data_in;
				wp_r <= ~wp_r;
			end
			if (tx_load) begin
				rp_r <= ~rp_r;
			end
		end
	end

	// Top CRC bit of every lane, sent during the CRC phase.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			crc_msb[i] = crc16_r[i][15];
		end
	end

	// Write packet state, driven on falling card clock edges.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			tstate_r <= srf_pkg::SRF_T_IDLE;
			width_r <= srf_pkg::SRF_W1;
			bytes_left_r <= 10'h000;
			beat_r <= 3'h0;
			crc_cnt_r <= 5'h00;
			cur_r <= 8'h00;
		end else begin
			case (tstate_r)
				srf_pkg::SRF_T_IDLE: begin
					if (wr_start_in && bstate_r == srf_pkg::SRF_B_IDLE) begin
						width_r <= srf_pkg::srf_width_t'(w_in);
						bytes_left_r <= len_sel;
						tstate_r <= srf_pkg::SRF_T_START;
					end
				end
				srf_pkg::SRF_T_START: begin
					beat_r <= 3'h0;
					crc_cnt_r <= 5'h00;
					if (sd_fall) begin
						tstate_r <= srf_pkg::SRF_T_DATA;
					end
				end
				srf_pkg::SRF_T_DATA: begin
					if (tx_load) begin
						cur_r <= mem_r[rp_r];
					end
					if (byte_end) begin
						beat_r <= 3'h0;
						bytes_left_r <= bytes_left_r - 10'h001;
						if (bytes_left_r == 10'h001) begin
							tstate_r <= srf_pkg::SRF_T_CRC;
						end
					end else if (tx_beat) begin
						beat_r <= beat_r + 3'h1;
					end
				end
				srf_pkg::SRF_T_CRC: begin
					if (sd_fall) begin
						crc_cnt_r <= crc_cnt_r + 5'h01;
						if (crc_cnt_r == `SRF_CRC16_LAST) begin
							tstate_r <= srf_pkg::SRF_T_END;
						end
					end
				end
				srf_pkg::SRF_T_END: begin
					if (sd_fall) begin
						tstate_r <= srf_pkg::SRF_T_STOP;
					end
				end
				default: begin
					if (sd_fall) begin
						tstate_r <= srf_pkg::SRF_T_IDLE;
					end
				end
			endcase
		end
	end

	// per-lane CRC16: cleared at the start bit, shifted out after.
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 8; i++) begin
			if (!nrst_in || tstate_r == srf_pkg::SRF_T_START) begin
				crc16_r[i] <= 16'h0000;
			end else if (tx_beat) begin
				crc16_r[i] <= crc16_step(crc16_r[i], tx_bits[i]);
			end else if (sd_fall && tstate_r == srf_pkg::SRF_T_CRC) begin
				crc16_r[i] <= {crc16_r[i][14:0], 1'b0};
			end
		end
	end

	// lane drive: start 0, data, CRC, end 1, then release.
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			dat_out <= 8'h00;
			dat_oe_out <= 8'h00;
			blk_done_out <= 1'b0;
		end else begin
			blk_done_out <= busy_req_blk;
			if (sd_fall) begin
				case (tstate_r)
					srf_pkg::SRF_T_START: begin
						dat_out <= 8'h00;
						dat_oe_out <= lanes;
					end
					srf_pkg::SRF_T_DATA: begin
						if (!starved) begin
							dat_out <= tx_bits & lanes;
						end
					end
					srf_pkg::SRF_T_CRC: dat_out <= crc_msb & lanes;
					srf_pkg::SRF_T_END: dat_out <= lanes;
					default: begin
						dat_out <= 8'h00;
						dat_oe_out <= 8'h00;
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_arm_long;
		resp_arm_in && arm_long;
	endsequence

	long_token_a: assert property (s_arm_long |=> bits_left_r == 8'h88)
		else $error("Long token not framed as 136 bits.");
	ocr_nocrc_a: assert property (resp_valid_out &&
		$past(kind_r) == srf_pkg::SRF_R3 |-> !resp_crc_err_out)
		else $error("CRC checked on an OCR response.");
	index_out_a: assert property (rx_done |=>
		resp_valid_out && resp_index_out == $past(sr_r[45:40]))
		else $error("Reported index differs from token bits 45:40.");
	blk_busy_a: assert property (busy_req_blk |=> busy_out [*2])
		else $error("No busy watch after a written block.");
	r1b_busy_a: assert property (busy_req_r1b &&
		bstate_r == srf_pkg::SRF_B_IDLE |=> busy_out)
		else $error("No busy watch after a busy response.");
	reg_hdr_a: assert property (rx_done && kind_r == srf_pkg::SRF_R2 &&
		sr_r[133:128] != 6'h3F |=> resp_frame_err_out)
		else $error("Register response header not checked.");
	lane_mask_a: assert property (dat_oe_out == 8'h00 ||
		dat_oe_out == 8'h01 || dat_oe_out == 8'h0F || dat_oe_out == 8'hFF)
		else $error("Illegal lane enable pattern.");
	one_bit_a: assert property (width_r == srf_pkg::SRF_W1 &&
		tstate_r != srf_pkg::SRF_T_START |-> dat_oe_out[7:1] == 7'h00)
		else $error("Upper lanes driven in 1-bit mode.");
	lock_flag_a: assert property (rx_done && is_r1 && !frame_bad &&
		!crc_bad |=> card_locked_out == resp_arg_out[25])
		else $error("Locked flag does not follow status bit 25.");
endmodule : srf_framer

//--- bench/srf_card_model.sv
// Card side model: link clock, response tokens, DAT0 busy and lane capture.
`timescale 1ns/1ns
module srf_card_model (
	// Host pins seen by the card.
	input wire logic [7:0] dat_in,
	input wire logic [7:0] dat_oe_in,
	// Card driven pins.
	output logic sd_clk_out,
	output logic cmd_out,
	output logic dat0_out
);
	logic busy_r;
	logic [7:0] cap_d[$];
	logic [7:0] cap_oe[$];

	// The host wins DAT0 while driving; otherwise the pull-up or card busy.
	assign dat0_out = dat_oe_in[0] ? dat_in[0] : ~busy_r;

	// Idle command and DAT0 lines rest on their pull-ups; the clock rests low.
	initial begin
		sd_clk_out = 1'b0;
		cmd_out = 1'b1;
		busy_r = 1'b0;
	end

	// Runs n link cycles; the clock stands low outside a run.
	task run(input logic [135:0] tok, input int len, input int n,
		input int bfrom, input int blen);
		for (int c = 0; c < n; c++) begin
			cmd_out = (c < len) ? tok[len - 1 - c] : 1'b1;
			busy_r = (c >= bfrom) && (c < bfrom + blen);
			#62 sd_clk_out = 1'b1;
			if (dat_oe_in !== 8'h00) begin
				cap_d.push_back(dat_in);
				cap_oe.push_back(dat_oe_in);
			end
			#63 sd_clk_out = 1'b0;
		end
		cmd_out = 1'b1;
		busy_r = 1'b0;
	endtask : run
endmodule : srf_card_model

//--- bench/sd_response_data_framing_test.sv
// Self-checking bench for the response receiver and write packet framer.
`timescale 1ns/1ns
`include "srf_defines.svh"
module sd_response_data_framing_test;
	logic clk_in, nrst_in, sd_clk, cmd, dat0, ok;
	logic [7:0] dat_out, dat_oe_out, wr_data_in, m, e;
	logic [7:0] wb[64];
	logic [15:0] c16[8];
	logic [135:0] t;
	logic [127:0] r;
	logic [31:0] a, resp_arg_out;
	logic [5:0] ix, cmd_index_in, resp_index_out;
	logic [3:0] resp_kind_in;
	logic [126:0] resp_reg_out;
	logic [1:0] bus_width_in;
	logic [9:0] blk_len_in;
	logic resp_arm_in, resp_valid_out, resp_crc_err_out, resp_frame_err_out;
	logic card_err_out, card_locked_out, busy_out, wr_start_in;
	logic sd_status_sel_in, blk_done_out, wr_valid_in, wr_ready_out;
	int n_mismatch, num_checks, n_valid, n_done, busy_cnt;
	int w, nl, len, beats, pkt, j, g;

	srf_framer i_srf_framer (.clk_in, .nrst_in, .sd_clk_in(sd_clk),
		.cmd_in(cmd), .dat0_in(dat0), .dat_out, .dat_oe_out, .resp_arm_in,
		.resp_kind_in, .cmd_index_in, .resp_valid_out, .resp_index_out,
		.resp_arg_out, .resp_reg_out, .resp_crc_err_out, .resp_frame_err_out,
		.card_err_out, .card_locked_out, .busy_out, .wr_start_in,
		.bus_width_in, .blk_len_in, .sd_status_sel_in, .blk_done_out,
		.wr_valid_in, .wr_data_in, .wr_ready_out);

	srf_card_model i_srf_card_model (.dat_in(dat_out), .dat_oe_in(dat_oe_out),
		.sd_clk_out(sd_clk), .cmd_out(cmd), .dat0_out(dat0));

	// System clock at 100 MHz.
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Pulses and busy time are counted where they are settled.
	always @(negedge clk_in) begin
		if (resp_valid_out === 1'b1) n_valid++;
		if (blk_done_out === 1'b1) n_done++;
		if (busy_out === 1'b1) busy_cnt++;
	end

	// CRC7 over token bits top down to 8, most significant first.
	function automatic logic [6:0] crc7(input logic [135:0] v, input int top);
		logic [6:0] c;
		c = 7'h00;
		for (int i = top; i >= 8; i--)
			c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? `SRF_CRC7_POLY : 7'h00);
		return c;
	endfunction : crc7

	// Short token; ones selects an all-ones CRC field.
	function automatic logic [135:0] tok48(input logic [5:0] idx,
		input logic [31:0] arg, input logic ones);
		logic [135:0] v;
		v = '0;
		v[47:0] = {2'b00, idx, arg, 7'h7F, 1'b1};
		if (ones !== 1'b1)
			v[7:1] = crc7(v, 47);
		return v;
	endfunction : tok48

	task chk(input logic okv, input string msg);
		num_checks++;
		if (okv !== 1'b1) begin
			n_mismatch++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask : chk

	task complete_run();
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// Arms the receiver, then lets the card send and hold busy.
	task resp(input logic [3:0] k, input logic [5:0] x,
		input logic [135:0] tk, input int ln, input int blen);
		@(negedge clk_in);
		resp_arm_in = 1'b1;
		resp_kind_in = k;
		cmd_index_in = x;
		@(negedge clk_in);
		resp_arm_in = 1'b0;
		n_valid = 0;
		busy_cnt = 0;
		i_srf_card_model.run(tk, ln, ln + 40, ln + 2, blen);
		@(negedge clk_in);
		chk(n_valid == 1, "response not reported once");
	endtask : resp

	// Offers one byte and holds it until ready is seen at a taking edge.
	task push(input logic [7:0] b);
		@(negedge clk_in);
		wr_valid_in = 1'b1;
		wr_data_in = b;
		for (g = 0; g < 4000 && wr_ready_out !== 1'b1; g++)
			@(negedge clk_in);
		if (g == 4000) begin
			n_mismatch++;
			$display("Error %0t: write stream stuck", $time);
			complete_run();
		end else
			@(posedge clk_in);
	endtask : push

	// Main sequence: reset, responses, busy, then write blocks.
	initial begin
		{nrst_in, resp_arm_in, wr_start_in, wr_valid_in} = 4'h0;
		{resp_kind_in, cmd_index_in, bus_width_in, blk_len_in} = '0;
		{sd_status_sel_in, wr_data_in} = '0;
		void'($urandom(32'hD852E5AF));
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		chk(dat_oe_out === 8'h00 && wr_ready_out === 1'b0, "reset state");
		nrst_in = 1'b1;
		repeat (3) @(negedge clk_in);
		// Plain responses with corner status words and broken framing.
		for (int i = 0; i < 8; i++) begin
			ix = 6'($urandom);
			// reported errors are gone from the next status.
			a = (i == 0) ? 32'h02000000 : (i == 1) ? 32'h04000000 :
				(i == 2) ? {6'h00, 26'($urandom)} : $urandom;
			t = tok48(ix, a, 1'b0);
			if (i == 4) t[1] = ~t[1];
			if (i == 5) t[0] = 1'b0;
			if (i == 6) t[46] = 1'b1;
			if (i == 6) t[7:1] = crc7(t, 47);
			resp(srf_pkg::SRF_R1, (i == 7) ? ix ^ 6'h01 : ix, t, 48, 0);
			if (i < 4) begin
				chk(resp_index_out === ix && resp_arg_out === a, "fields");
				chk(resp_crc_err_out === 1'b0, "good CRC refused");
				chk(card_err_out === (|a[31:26]), "error flags");
				chk(card_locked_out === a[25], "lock flag");
				chk(busy_cnt == 0, "busy without busy kind");
			end else if (i == 4)
				chk(resp_crc_err_out === 1'b1, "bad CRC passed");
			else
				chk(resp_frame_err_out === 1'b1, "bad frame passed");
		end
		// Every other short kind, good and with a broken fixed field.
		for (int k = 3; k < 10; k++) begin
			for (int v = 0; v < 3; v++) begin
				a = $urandom;
				case (k)
					3, 5: ix = `SRF_IDX_ONES;
					4: ix = `SRF_IDX_FASTIO;
					6: ix = `SRF_IDX_IRQ;
					7: ix = {`SRF_IDX_IOACC_HI, a[0]};
					8: ix = `SRF_IDX_RCA;
					default: ix = `SRF_IDX_IFCOND;
				endcase
				if (k == 5) a[26:24] = 3'h0;
				if (k == 7) a[31:16] = 16'h0000;
				if (k == 9) a[31:12] = 20'h00000;
				if (v == 1) ix[4] = ~ix[4];
				if (v == 2) a[26] = 1'b1;
				t = tok48(ix, a, k == 3 || k == 5);
				if (v < 2 || k == 5 || k == 7 || k == 9) begin
					resp(4'(k), 6'h00, t, 48, 0);
					chk(resp_frame_err_out === (v != 0) &&
						resp_crc_err_out === 1'b0 &&
						(v != 0 || resp_arg_out === a), "kind");
				end
			end
		end
		// Long register token, then with a hole in its ones field.
		r = {$urandom, $urandom, $urandom, $urandom};
		t = '0;
		t[133:128] = 6'h3F;
		t[127:8] = r[119:0];
		t[7:1] = crc7(t, 127);
		t[0] = 1'b1;
		resp(srf_pkg::SRF_R2, 6'h00, t, 136, 0);
		chk(resp_reg_out === t[127:1] && resp_crc_err_out === 1'b0, "R2");
		t[130] = 1'b0;
		resp(srf_pkg::SRF_R2, 6'h00, t, 136, 0);
		chk(resp_frame_err_out === 1'b1, "register ones field");
		// Busy response without and with the card holding DAT0 low.
		for (int v = 0; v < 2; v++) begin
			ix = 6'($urandom);
			resp(srf_pkg::SRF_R1B, ix, tok48(ix, $urandom, 1'b0), 48, v * 16);
			chk(busy_out === 1'b0 && busy_cnt >= (v ? 150 : 80) &&
				busy_cnt <= (v ? 400 : 120), "busy watch");
		end
		// Write blocks in each width, a status block, then spare width code.
		for (int i = 0; i < 5; i++) begin
			w = (i == 3) ? 2 : (i == 4) ? 0 : i;
			nl = (w == 0) ? 1 : (w == 1) ? 4 : 8;
			m = (w == 0) ? `SRF_LANES_1 : (w == 1) ? `SRF_LANES_4 : `SRF_LANES_8;
			len = (i == 3) ? 64 : 4;
			beats = len * 8 / nl;
			pkt = beats + 18;
			for (int b = 0; b < len; b++)
				wb[b] = 8'($urandom);
			i_srf_card_model.cap_d.delete();
			i_srf_card_model.cap_oe.delete();
			@(negedge clk_in);
			wr_start_in = 1'b1;
			bus_width_in = (i == 4) ? 2'h3 : 2'(w);
			blk_len_in = (i == 3) ? 10'h003 : 10'h004;
			sd_status_sel_in = (i == 3);
			@(negedge clk_in);
			wr_start_in = 1'b0;
			push(wb[0]);
			push(wb[1]);
			@(negedge clk_in);
			wr_valid_in = 1'b0;
			@(negedge clk_in);
			chk(wr_ready_out === 1'b0, "buffer took a third byte");
			n_done = 0;
			busy_cnt = 0;
			fork
				begin
					for (int b = 2; b < len; b++)
						push(wb[b]);
					@(negedge clk_in);
					wr_valid_in = 1'b0;
				end
				i_srf_card_model.run('1, 0, pkt + 26, pkt + 6, 16);
			join
			@(negedge clk_in);
			ok = (i_srf_card_model.cap_d.size() == pkt);
			for (int l = 0; l < 8; l++)
				c16[l] = 16'h0000;
			for (int s = 0; s < pkt && ok; s++) begin
				e = 8'h00;
				for (int l = 0; l < nl; l++) begin
					if (s == pkt - 1)
						e[l] = 1'b1;
					else if (s > beats)
						e[l] = c16[l][16 + beats - s];
					else if (s > 0) begin
						j = (s - 1) * nl;
						e[l] = wb[j / 8][8 - nl - j % 8 + l];
						c16[l] = {c16[l][14:0], 1'b0} ^
							((e[l] ^ c16[l][15]) ? `SRF_CRC16_POLY : 16'h0000);
					end
				end
				ok = ok && i_srf_card_model.cap_oe[s] === m &&
					(i_srf_card_model.cap_d[s] & m) === e;
			end
			chk(ok, "data packet lanes");
			chk(n_done == 1 && busy_cnt > 150 && busy_out === 1'b0, "busy");
		end
		complete_run();
	end
endmodule : sd_response_data_framing_test
